// ==== fcs_flash_command_sequencer.v ====
// Flash command sequencer with a classic Wishbone register slave.
// Assumes a single 10 MHz bus clock, a synchronous reset and option straps
// and context levels that come from logic on the same clock.
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "fcs_defines.vh"
module fcs_flash_command_sequencer #(
    parameter [14:0] PROG_PERIODS = `FCS_PER_PROG,
    parameter [14:0] BURST_PERIODS = `FCS_PER_BURST,
    parameter [14:0] PAGE_PERIODS = `FCS_PER_PAGE,
    parameter [14:0] MASS_PERIODS = `FCS_PER_MASS,
    parameter [14:0] BLANK_PERIODS = `FCS_PER_BLANK
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [16:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Access context
    input wire bdm_access_i,
    input wire secure_code_i,
    input wire stop_mode_i,
    // Nonvolatile options
    input wire key_enable_strap_i,
    input wire [1:0] security_strap_i,
    input wire [63:0] backdoor_key_i,
    // Flash array
    input wire array_blank_i,
    output reg exec_o,
    output reg pump_o,
    output reg [7:0] op_o,
    output reg [15:0] addr_o,
    output reg [7:0] data_o,
    output reg secured_o
);

// ----------------------------------------------------------------------------
// Decode helpers
// ----------------------------------------------------------------------------
// The command sequence walks idle, address latched, command latched.
// A bus protocol fault returns it to idle unless a stop abort falls in the same cycle; every fault sets the access error flag.
// Launch from the command state also returns it to idle, while the
// buffered command waits in the buffer until the executor is free.
localparam SEQ_IDLE = 2'd0;
localparam SEQ_ADDR = 2'd1;
localparam SEQ_CMD = 2'd2;

// Only the five defined command codes are accepted by the command register.
// Codes outside this set raise an access error when written.
function fcs_valid;
    input [7:0] code;
    begin
        fcs_valid = (code == `FCS_CMD_BLANK) || (code == `FCS_CMD_PAGE) ||
                    (code == `FCS_CMD_MASS) || (code == `FCS_CMD_PROG) ||
                    (code == `FCS_CMD_BURST);
    end
endfunction

// Blank check only reads the array and so never needs high voltage.
function fcs_hv;
    input [7:0] code;
    begin
        fcs_hv = fcs_valid(code) && (code != `FCS_CMD_BLANK);
    end
endfunction

// Standard length of each command in timing clock periods. Burst bytes
// that follow in the same row use the shorter burst length instead.
function [14:0] fcs_periods;
    input [7:0] code;
    begin
        case (code)
            `FCS_CMD_PAGE: fcs_periods = PAGE_PERIODS;
            `FCS_CMD_MASS: fcs_periods = MASS_PERIODS;
            `FCS_CMD_BLANK: fcs_periods = BLANK_PERIODS;
            default: fcs_periods = PROG_PERIODS;
        endcase
    end
endfunction

// ----------------------------------------------------------------------------
// State
// ----------------------------------------------------------------------------
// The buffer holds one launched command, so a burst byte can be queued
// while the previous byte is still being programmed.
// The key index counts in-order comparison key writes, right byte or wrong; the bad flag
// remembers any wrong byte, address or source until key access reopens.
reg [1:0] seq_reg;
reg [5:0] flash_clock_divider_reg;
reg div_loaded_reg;
reg access_error_flag_reg;
reg command_buffer_empty_flag_reg;
reg command_complete_flag_reg;
reg blank_reg;
reg backdoor_key_enable_reg;
reg [1:0] security_state_bits_reg;
reg strap_pend_reg;
reg key_access_reg;
reg [3:0] key_idx_reg;
reg key_bad_reg;
reg [15:0] buf_addr_reg;
reg [7:0] buf_data_reg;
reg [7:0] flash_command_reg;
reg buf_full_reg;
reg [5:0] presc_reg;
reg [14:0] cnt_reg;
reg [7:0] rdata;

// ----------------------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------------------
// A request is taken while ack is low and acts at the edge that sees ack.
// Registers sit one to a word in the low byte; bit 16 selects the array.
// Offsets above the command register, and any address with bits 15 to 5
// set, fall outside the block: they read zero and writes are ignored.
wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire acc = wb_cyc_i & wb_stb_i & wb_ack_o;
wire arr = wb_adr_i[16];
wire [4:0] off = {wb_adr_i[4:2], 2'b00};
wire hit = ~arr && (wb_adr_i[15:5] == 11'h000) && (off <= `FCS_OFF_CMD);
wire wr = acc & wb_we_i & wb_sel_i[0];
wire [7:0] wd = wb_dat_i[7:0];
wire arr_wr = wr & arr;
wire is_div = hit && (off == `FCS_OFF_DIV);
wire is_cfg = hit && (off == `FCS_OFF_CFG);
wire is_stat = hit && (off == `FCS_OFF_STAT);
wire is_cmd = hit && (off == `FCS_OFF_CMD);
// Security counts as engaged for every state of the bits but the open one.
wire secured = security_state_bits_reg != `FCS_SEC_OPEN;
wire launch_wr = wr & is_stat & wd[`FCS_ST_CBE_BIT];
wire err_clr = wr & is_stat & wd[`FCS_ST_ERR_BIT];

// ----------------------------------------------------------------------------
// Access error detection
// ----------------------------------------------------------------------------
// Every protocol fault is gathered into one set term. A fault in the
// same cycle as a clear by software wins, so no violation is ever lost.
// Array writes made while key access is open are key entries, not
// command steps, and so never count as a fault of the sequence.
// Stop mode only aborts commands that use high voltage; a blank check
// in progress runs on to its end.
wire err_arr = arr_wr & ~key_access_reg &
               (~div_loaded_reg | ~command_buffer_empty_flag_reg | (seq_reg != SEQ_IDLE));
wire err_addr = acc & hit & wb_we_i & ~is_cmd & (seq_reg == SEQ_ADDR);
wire err_cmdst = acc & hit & (seq_reg == SEQ_CMD) & ~launch_wr;
wire err_code = wr & is_cmd & ((seq_reg != SEQ_ADDR) | ~fcs_valid(wd));
wire err_dbg = wr & is_cmd & bdm_access_i & secured &
               ((wd == `FCS_CMD_PROG) | (wd == `FCS_CMD_BURST) | (wd == `FCS_CMD_PAGE));
wire err_stop = stop_mode_i & exec_o & fcs_hv(op_o);
wire err_set = err_arr | err_addr | err_cmdst | err_code | err_dbg | err_stop;

// ----------------------------------------------------------------------------
// Execution timing
// ----------------------------------------------------------------------------
// The prescaler divides the bus clock by divider plus one. It restarts
// at every start so the first period of a command is always whole.
// A burst byte chains straight on from the one before only when it was
// queued in time and lies in the same row but not at the row start;
// the pump then stays on and the byte takes the burst length.
// Anything else ends the command, drops the pump and starts afresh.
wire tick = presc_reg == flash_clock_divider_reg;
wire done = exec_o & tick & (cnt_reg == 15'h0001) & ~err_stop;
wire chain = done & pump_o & buf_full_reg & (op_o == `FCS_CMD_BURST) &
             (flash_command_reg == `FCS_CMD_BURST) &
             (buf_addr_reg[15:6] == addr_o[15:6]) & (buf_addr_reg[5:0] != 6'h00);
// A pending access error holds back the start of a buffered command.
wire start = buf_full_reg & ~exec_o & ~access_error_flag_reg;
wire launch = launch_wr & (seq_reg == SEQ_CMD) & ~err_set;
// Key bytes must arrive in order at consecutive key locations, from
// secure code and never through background debug. A wrong step marks
// the attempt bad until key access is opened again.
wire key_wr = arr_wr & key_access_reg;
wire key_ok = secure_code_i & ~bdm_access_i & (key_idx_reg < 4'h8) &
              (wb_adr_i[15:0] == (`FCS_KEY_BASE + {12'h000, key_idx_reg}));
wire [7:0] key_byte = backdoor_key_i[{key_idx_reg[2:0], 3'b000} +: 8];

// Read data multiplexer; unmapped locations read as zero.
always @* begin
    rdata = 8'h00;
    if (hit) begin
        case (off)
            `FCS_OFF_DIV: rdata = {div_loaded_reg, 1'b0, flash_clock_divider_reg};
            `FCS_OFF_OPT: rdata = {backdoor_key_enable_reg, 5'h00, security_state_bits_reg};
            `FCS_OFF_CFG: rdata = {2'b00, key_access_reg, 5'h00};
            `FCS_OFF_STAT: rdata = {command_buffer_empty_flag_reg, command_complete_flag_reg, 1'b0,
                                    access_error_flag_reg, 1'b0, blank_reg, 2'b00};
            `FCS_OFF_CMD: rdata = flash_command_reg;
            default: rdata = 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------------------
// Bus slave
// ----------------------------------------------------------------------------
// Answers every request one cycle later; effects act at the edge that sees ack.
// Read data stands only in the ack cycle and is zero otherwise, which
// keeps a shared read bus quiet.
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= req;
        wb_dat_o <= req ? {24'h000000, rdata} : 32'h00000000;
    end
end

// ----------------------------------------------------------------------------
// Options, divider, key and error flag
// ----------------------------------------------------------------------------
// Security opens either by a blank check that finds the array blank or
// by closing key access after all eight key bytes matched with the key
// enabled. It stays open until the next reset.
// The divider loads once per reset and never while an error is pending.
always @(posedge clk_i) begin
    if (rst_i) begin
        strap_pend_reg <= 1'b1;
        backdoor_key_enable_reg <= 1'b0;
        security_state_bits_reg <= `FCS_SEC_RST;
        secured_o <= 1'b1;
        div_loaded_reg <= 1'b0;
        flash_clock_divider_reg <= `FCS_DIV_RST;
        access_error_flag_reg <= 1'b0;
        key_access_reg <= 1'b0;
        key_idx_reg <= 4'h0;
        key_bad_reg <= 1'b0;
    end else begin
        secured_o <= secured;
        // Straps are caught on the first edge after reset release.
        if (strap_pend_reg) begin
            strap_pend_reg <= 1'b0;
            backdoor_key_enable_reg <= key_enable_strap_i;
            security_state_bits_reg <= security_strap_i;
        end else if (done & (op_o == `FCS_CMD_BLANK) & array_blank_i) begin
            security_state_bits_reg <= `FCS_SEC_OPEN;
        end else if (wr & is_cfg & ~err_set & key_access_reg & ~wd[`FCS_CFG_KEYACC_BIT] &
                     backdoor_key_enable_reg & ~key_bad_reg & (key_idx_reg == 4'h8)) begin
            security_state_bits_reg <= `FCS_SEC_OPEN;
        end
        if (wr & is_div & ~div_loaded_reg & ~access_error_flag_reg & ~err_set) begin
            div_loaded_reg <= 1'b1;
            flash_clock_divider_reg <= wd[5:0];
        end
        access_error_flag_reg <= err_set | (access_error_flag_reg & ~err_clr);
        if (wr & is_cfg & ~err_set) begin
            key_access_reg <= wd[`FCS_CFG_KEYACC_BIT];
            if (wd[`FCS_CFG_KEYACC_BIT] & ~key_access_reg) begin
                key_idx_reg <= 4'h0;
                key_bad_reg <= 1'b0;
            end
        end else if (key_wr) begin
            if (key_ok) begin
                key_idx_reg <= key_idx_reg + 4'h1;
                key_bad_reg <= key_bad_reg | (wd != key_byte);
            end else begin
                key_bad_reg <= 1'b1;
            end
        end
    end
end

// ----------------------------------------------------------------------------
// Command sequence and buffer
// ----------------------------------------------------------------------------
// A launch fills the buffer and clears the buffer empty flag. The flag
// returns as soon as the executor takes the command, so software may
// queue the next burst byte while this one is still programming.
// An error from the bus returns the sequence to idle unless a stop abort
// comes in the same cycle; a stop abort leaves it alone, since software may be in the middle of a sequence.
always @(posedge clk_i) begin
    if (rst_i) begin
        seq_reg <= SEQ_IDLE;
        buf_addr_reg <= 16'h0000;
        buf_data_reg <= 8'h00;
        flash_command_reg <= 8'h00;
        buf_full_reg <= 1'b0;
        command_buffer_empty_flag_reg <= 1'b1;
    end else begin
        if (err_set & ~err_stop) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            case (seq_reg)
                SEQ_IDLE: begin
                    if (arr_wr & ~key_access_reg & ~access_error_flag_reg) begin
                        buf_addr_reg <= wb_adr_i[15:0];
                        buf_data_reg <= wd;
                        seq_reg <= SEQ_ADDR;
                    end
                end
                SEQ_ADDR: begin
                    if (wr & is_cmd) begin
                        flash_command_reg <= wd;
                        seq_reg <= SEQ_CMD;
                    end
                end
                SEQ_CMD: begin
                    if (launch) begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
                default: seq_reg <= SEQ_IDLE;
            endcase
        end
        if (launch) begin
            buf_full_reg <= 1'b1;
            command_buffer_empty_flag_reg <= 1'b0;
        end else if (start | chain) begin
            buf_full_reg <= 1'b0;
            command_buffer_empty_flag_reg <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------------------
// Execution
// ----------------------------------------------------------------------------
// The complete flag is held low while a command is buffered or being
// launched, so software sees completion only when the queue is drained.
// A stop abort counts as completion only if nothing else is waiting.
// The command code, address and data outputs hold their last values
// after a command ends.
always @(posedge clk_i) begin
    if (rst_i) begin
        exec_o <= 1'b0;
        pump_o <= 1'b0;
        op_o <= 8'h00;
        addr_o <= 16'h0000;
        data_o <= 8'h00;
        cnt_reg <= 15'h0000;
        presc_reg <= 6'h00;
        command_complete_flag_reg <= 1'b1;
        blank_reg <= 1'b0;
    end else begin
        presc_reg <= (start | tick) ? 6'h00 : presc_reg + 6'h01;
        if (launch) begin
            command_complete_flag_reg <= 1'b0;
            blank_reg <= 1'b0;
        end
        if (err_stop) begin
            exec_o <= 1'b0;
            pump_o <= 1'b0;
            command_complete_flag_reg <= ~buf_full_reg & ~launch;
        end else if (start | chain) begin
            exec_o <= 1'b1;
            pump_o <= fcs_hv(flash_command_reg);
            op_o <= flash_command_reg;
            addr_o <= buf_addr_reg;
            data_o <= buf_data_reg;
            cnt_reg <= chain ? BURST_PERIODS : fcs_periods(flash_command_reg);
        end else if (done) begin
            exec_o <= 1'b0;
            pump_o <= 1'b0;
            if (op_o == `FCS_CMD_BLANK) begin
                blank_reg <= array_blank_i;
            end
            if (~buf_full_reg & ~launch) begin
                command_complete_flag_reg <= 1'b1;
            end
        end else if (exec_o & tick) begin
            cnt_reg <= cnt_reg - 15'h0001;
        end
    end
end

endmodule

// ==== fcs_defines.vh ====
// Constants of the flash command sequencer: register offsets, field positions,
// reset values, command codes and timing counts.
// Assumes inclusion by bare name from the design file.
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FCS_OFF_DIV 5'h00
`define FCS_OFF_OPT 5'h04
`define FCS_OFF_CFG 5'h08
`define FCS_OFF_STAT 5'h0c
`define FCS_OFF_CMD 5'h10

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define FCS_DIV_LOADED_BIT 7
`define FCS_OPT_BACKDOOR_KEY_ENABLE_BIT 7
`define FCS_CFG_KEYACC_BIT 5
`define FCS_ST_CBE_BIT 7
`define FCS_ST_CCF_BIT 6
`define FCS_ST_ERR_BIT 4
`define FCS_ST_BLANK_BIT 2
`define FCS_DIV_RST 6'h00
`define FCS_SEC_RST 2'h3
`define FCS_SEC_OPEN 2'h2

// ----------------------------------------------------------------------------
// Command codes, key window and timing counts in timing clock periods
// ----------------------------------------------------------------------------
`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_PROG 8'h20
`define FCS_CMD_BURST 8'h25
`define FCS_CMD_PAGE 8'h40
`define FCS_CMD_MASS 8'h41
`define FCS_KEY_BASE 16'hffb0
`define FCS_PER_PROG 15'h0009
`define FCS_PER_BURST 15'h0004
`define FCS_PER_PAGE 15'h0fa0
`define FCS_PER_MASS 15'h4e20
`define FCS_PER_BLANK 15'h0001
`endif

// ==== fcs_sequencer_props.sv ====
// Concurrent checks on the ports of the flash command sequencer.
// Assumes a bind to the sequencer top module and one bus clock domain.
`timescale 1ns/100ps
module fcs_sequencer_props (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [31:0] wb_dat_o,
    // Context and array side
    input wire stop_mode_i,
    input wire exec_o,
    input wire pump_o,
    input wire [7:0] op_o,
    input wire secured_o
);
    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence stop_s;
        stop_mode_i && pump_o;
    endsequence
    ack_latency_a: assert property (req_s |=> wb_ack_o)
        else $error("ack missing one cycle after a request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    pump_exec_a: assert property (pump_o |-> exec_o)
        else $error("pump on while nothing executes");
    op_valid_a: assert property ($rose(exec_o) |-> op_o inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
        else $error("execution started with an invalid code");
    blank_pump_a: assert property (exec_o && op_o == 8'h05 |-> !pump_o)
        else $error("pump on during blank check");
    stop_abort_a: assert property (stop_s |-> ##[1:3] !exec_o && !pump_o)
        else $error("stop did not abort the command");
    pump_fall_a: assert property ($fell(pump_o) |-> !exec_o)
        else $error("pump dropped inside a running command");
    op_hold_a: assert property (exec_o && $past(exec_o) |-> $stable(op_o))
        else $error("command code changed during execution");
    reset_idle_a: assert property (disable iff (1'b0) rst_i |=> !exec_o && !wb_ack_o && secured_o)
        else $error("outputs not idle after reset");
endmodule

// ==== fcs_array_model.sv ====
// Behavioural flash array that answers blank checks.
// Assumes the sequencer clock and reset.
`timescale 1ns/100ps
module fcs_array_model (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Sequencer side
    input wire exec_o,
    input wire [7:0] op_o,
    output reg array_blank_i
);
    // ------------------------------------------------------------------------
    // Array contents state
    // ------------------------------------------------------------------------
    reg exec_reg;
    initial array_blank_i = 1'b0;
    always @(posedge clk_i) begin
        exec_reg <= exec_o;
        if (rst_i) begin
            array_blank_i <= 1'b0;
        end else if (exec_reg && !exec_o && op_o == 8'h41) begin
            array_blank_i <= 1'b1;
        end else if (exec_reg && !exec_o && op_o[7:4] == 4'h2) begin
            array_blank_i <= 1'b0;
        end
    end
endmodule

// ==== tb_flash_command_sequencer.sv ====
// Self-checking bench for the flash command sequencer.
// Assumes a 10 MHz clock and the array model on the far side.
`timescale 1ns/100ps
module tb_flash_command_sequencer;
    localparam P = 50;
    localparam [63:0] KEY = 64'h0f1e2d3c4b5a6978;
    localparam [16:0] DIV = 17'h00000;
    localparam [16:0] CFG = 17'h00008;
    localparam [16:0] ST = 17'h0000c;
    localparam [16:0] CMD = 17'h00010;
    localparam [16:0] ARR = 17'h10100;
    localparam [31:0] CODES = 32'h20404105;
    localparam int PERS [0:3] = '{9, 20, 40, 1};
    reg clk_i, rst_i, cyc, stb, we, background_debug_mode, scode, stop;
    reg [16:0] adr;
    reg [31:0] wdat;
    reg [7:0] q;
    wire [31:0] rdat;
    wire ack, blank, exec, pump, secured;
    wire [7:0] op, dout;
    wire [15:0] addr;
    integer bad_count, comparisons, ec, pc, i;
    // ------------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------------
    fcs_flash_command_sequencer #(.PAGE_PERIODS(15'd20), .MASS_PERIODS(15'd40)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .bdm_access_i(background_debug_mode), .secure_code_i(scode), .stop_mode_i(stop),
        .key_enable_strap_i(1'b1), .security_strap_i(2'h3), .backdoor_key_i(KEY), .array_blank_i(blank),
        .exec_o(exec), .pump_o(pump), .op_o(op), .addr_o(addr), .data_o(dout), .secured_o(secured));
    fcs_array_model u_array (.clk_i(clk_i), .rst_i(rst_i), .exec_o(exec), .op_o(op), .array_blank_i(blank));
    // ------------------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------------------
    task check(input string nm, input [31:0] e, input [31:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task acc(input [16:0] a, input w, input [7:0] d, output [7:0] r);
        integer n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        n = 0;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n = n + 1;
        end
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        check("ack", 1, n < 20);
        @(posedge clk_i);
    endtask
    task wr(input [16:0] a, input [7:0] d);
        acc(a, 1'b1, d, q);
    endtask
    task seq3(input [15:0] a, input [7:0] d, input [7:0] c);
        wr({1'b1, a}, d);
        wr(CMD, c);
        wr(ST, 8'h80);
    endtask
    task measure(output integer e, output integer p);
        integer w;
        w = 0;
        e = 0;
        p = 0;
        while (exec !== 1'b1 && w < 20) begin
            @(posedge clk_i);
            w = w + 1;
        end
        while (exec === 1'b1 && e < 3000) begin
            e = e + 1;
            p = p + (pump === 1'b1);
            @(posedge clk_i);
        end
    endtask
    task err_case(input [16:0] a2, input [7:0] d2, input two, input [16:0] a3, input w3);
        wr(ARR, 8'h11);
        wr(a2, d2);
        if (two) acc(a3, w3, 8'h20, q);
        acc(ST, 1'b0, 8'h0, q);
        check("error flag", 1, q[4]);
        wr(ST, 8'h10);
        acc(ST, 1'b0, 8'h0, q);
        check("error cleared", 8'hc0, q);
    endtask
    task key_try(input b, input exp);
        background_debug_mode <= b;
        scode <= !b;
        wr(CFG, 8'h20);
        for (i = 0; i < 8; i = i + 1) wr({1'b1, 16'hffb0 + i[15:0]}, KEY[8*i +: 8]);
        wr(CFG, 8'h00);
        background_debug_mode <= 1'b0;
        scode <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("secured", exp, secured);
    endtask
    task final_report;
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        bad_count = bad_count + 1;
        final_report;
    end
    initial begin
        {rst_i, cyc, stb, we, background_debug_mode, stop, scode, adr, wdat} = {7'h41, 17'h0, 32'h0};
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        acc(ST, 1'b0, 8'h0, q);
        check("status reset", 8'hc0, q);
        acc(17'h00004, 1'b0, 8'h0, q);
        check("options", 8'h83, q);
        wr(17'h00014, 8'hff);
        acc(17'h00014, 1'b0, 8'h0, q);
        check("unmapped", 8'h00, q);
        wr(ARR, 8'h00);
        acc(ST, 1'b0, 8'h0, q);
        check("no divider", 8'hd0, q);
        wr(DIV, 8'h31);
        acc(DIV, 1'b0, 8'h0, q);
        check("divider blocked", 8'h00, q);
        wr(ST, 8'h10);
        wr(DIV, 8'h31);
        wr(DIV, 8'h05);
        acc(DIV, 1'b0, 8'h0, q);
        check("divider once", 8'hb1, q);
        err_case(ST, 8'h00, 1'b0, DIV, 1'b0);
        err_case(ARR, 8'h22, 1'b0, DIV, 1'b0);
        err_case(CMD, 8'h33, 1'b0, DIV, 1'b0);
        err_case(CFG, 8'h00, 1'b0, DIV, 1'b0);
        err_case(CMD, 8'h20, 1'b1, CMD, 1'b1);
        err_case(CMD, 8'h20, 1'b1, DIV, 1'b0);
        background_debug_mode <= 1'b1;
        err_case(CMD, 8'h40, 1'b0, DIV, 1'b0);
        background_debug_mode <= 1'b0;
        key_try(1'b1, 1'b1);
        key_try(1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            seq3(16'h1345, 8'h5a, CODES[31-8*k -: 8]);
            measure(ec, pc);
            check("duration", 1, ec >= P * PERS[k] && ec <= P * PERS[k] + 1);
            check("op", CODES[31-8*k -: 8], op);
            check("addr", 16'h1345, addr);
            check("data", 8'h5a, dout);
            acc(ST, 1'b0, 8'h0, q);
            check("complete", k == 3 ? 8'hc4 : 8'hc0, q);
        end
        seq3(16'h2000, 8'h01, 8'h25);
        fork
            measure(ec, pc);
            seq3(16'h2001, 8'h02, 8'h25);
        join
        check("burst time", 1, ec >= P * 13 && ec <= P * 13 + 1);
        check("burst pump", ec, pc);
        check("burst addr", 16'h2001, addr);
        seq3(16'h203f, 8'h03, 8'h25);
        fork
            measure(ec, pc);
            seq3(16'h2040, 8'h04, 8'h25);
        join
        check("row end", 1, ec >= P * 9 && ec <= P * 9 + 1);
        measure(ec, pc);
        check("row start", 1, ec >= P * 9 && ec <= P * 9 + 1);
        seq3(16'h1200, 8'h00, 8'h40);
        repeat (5) @(posedge clk_i);
        stop <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("stop exec", 0, exec);
        stop <= 1'b0;
        acc(ST, 1'b0, 8'h0, q);
        check("stop error", 1, q[4]);
        final_report;
    end
endmodule
bind fcs_flash_command_sequencer fcs_sequencer_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .stop_mode_i(stop_mode_i), .exec_o(exec_o),
    .pump_o(pump_o), .op_o(op_o), .secured_o(secured_o));
